// [watchdog_and_sleep_wake_control_test.sv]
`timescale 1ns/1ps
`include "wsc_map.svh"
module watchdog_and_sleep_wake_control_test;
	logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, watchdog_enable_fuse = 1'h1;
	logic crystal_mode = 1'h0, master_clear_pin_n = 1'h1, watchdog_clear_instruction = 1'h0;
	logic sleep_instruction = 1'h0, irq_pending = 1'h0, global_interrupt_enable = 1'h0;
	logic device_reset, master_clear_pin_oe_n, timeout_status_flag, powerdown_status_flag;
	logic osc_drive_en, io_hold, prefetch_next, resume_exec, vector_to_isr, sleeping, irq;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int n_errors = 0, checks = 0;
	// Short base count keeps every time-out within 1024 cycles
	wsc_top #(.WDT_CYCLES(8)) DUT (.*);
	always #5 aclk = ~aclk;
	task automatic chk(input logic c, input string m);
		checks++;
		if (c !== 1'h1) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	// Bus tasks hold each channel until its own handshake edge, then idle one cycle
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp === 2'h0, "bresp");
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : rd
	// Straps are only sampled while reset is held
	task automatic do_reset(input logic f, input logic x);
		aresetn <= 1'h0;
		watchdog_enable_fuse <= f;
		crystal_mode <= x;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
	endtask : do_reset
	task automatic kick;
		watchdog_clear_instruction <= 1'h1;
		@(posedge aclk);
		watchdog_clear_instruction <= 1'h0;
	endtask : kick
	// Returns where the sleep entry outputs are visible
	task automatic doze;
		sleep_instruction <= 1'h1;
		@(posedge aclk);
		sleep_instruction <= 1'h0;
		@(posedge aclk);
	endtask : doze
	// A late kick must restart the full period
	task automatic expire(input int p);
		int n;
		kick();
		repeat (p - 2) begin
			@(posedge aclk);
			chk(!device_reset, "early reset");
		end
		kick();
		n = 0;
		while (device_reset !== 1'h1 && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		chk(n >= p - 1 && n <= p + 3 && !timeout_status_flag, "period");
		kick();
	endtask : expire
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd(`WSC_OPTION_ADDR, d, r);
		chk(d[7:0] === 8'hFF && r === 2'h0, "option reset");
		wr(`WSC_OPTION_ADDR, 32'h5F);
		rd(`WSC_OPTION_ADDR, d, r);
		chk(d[7:0] === 8'h5F, "option rw");
		rd(12'h100, d, r);
		chk(r === 2'h2, "unmapped");
	endtask : t_regs
	task automatic t_wdt;
		for (int r = 0; r < 4; r++) begin
			wr(`WSC_OPTION_ADDR, 32'h8 | 32'(r));
			expire(8 << r);
		end
		wr(`WSC_OPTION_ADDR, 32'hF7);
		expire(8);
	endtask : t_wdt
	// Clock enable low must freeze the count, so the period resumes where it stopped
	task automatic t_freeze;
		int n;
		kick();
		clk_en <= 1'h0;
		repeat (20) begin
			@(posedge aclk);
			chk(!device_reset && timeout_status_flag, "frozen");
		end
		clk_en <= 1'h1;
		n = 0;
		while (device_reset !== 1'h1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		chk(n >= 7 && n <= 11, "thawed period");
		kick();
	endtask : t_freeze
	// Only the wake event is unmasked, so sleep entry alone leaves irq low
	task automatic t_sleep_irq;
		logic [31:0] d;
		logic [1:0] r;
		wr(`WSC_OPTION_ADDR, 32'hF);
		wr(`WSC_IRQ_MASK_ADDR, 32'h2);
		for (int g = 0; g < 2; g++) begin
			rd(`WSC_IRQ_STAT_ADDR, d, r);
			global_interrupt_enable <= g[0];
			doze();
			chk(sleeping && prefetch_next && !powerdown_status_flag, "entry");
			chk(timeout_status_flag && io_hold && !osc_drive_en, "hold");
			repeat (3) begin
				@(posedge aclk);
				chk(sleeping && !irq, "asleep");
			end
			irq_pending <= 1'h1;
			@(posedge aclk);
			irq_pending <= 1'h0;
			@(posedge aclk);
			chk(resume_exec && vector_to_isr === g[0] && !io_hold, "wake");
		end
		@(posedge aclk);
		chk(irq === 1'h1, "irq set");
		rd(`WSC_IRQ_STAT_ADDR, d, r);
		chk(d[2:0] === 3'h6, "irq status");
		@(posedge aclk);
		chk(irq === 1'h0, "irq clear");
	endtask : t_sleep_irq
	task automatic t_sleep_wdt;
		int n;
		wr(`WSC_OPTION_ADDR, 32'h8);
		doze();
		n = 0;
		while (sleeping === 1'h1 && n < 100) begin
			@(posedge aclk);
			n++;
			chk(!device_reset, "reset in sleep");
		end
		chk(n >= 6 && n <= 11 && !timeout_status_flag, "wdt wake");
		kick();
	endtask : t_sleep_wdt
	task automatic t_master_clear_pin;
		int n;
		wr(`WSC_OPTION_ADDR, 32'hF);
		irq_pending <= 1'h1;
		doze();
		irq_pending <= 1'h0;
		chk(prefetch_next && resume_exec && osc_drive_en, "pending");
		doze();
		master_clear_pin_n <= 1'h0;
		n = 0;
		while (device_reset !== 1'h1 && n < 20) begin
			@(posedge aclk);
			n++;
		end
		master_clear_pin_n <= 1'h1;
		@(posedge aclk);
		chk(n < 8 && !sleeping && master_clear_pin_oe_n, "master clear");
	endtask : t_master_clear_pin
	// Fuse is off here, so the long start-up wait cannot be cut by an expiry
	task automatic t_xtal;
		int n;
		wr(`WSC_OPTION_ADDR, 32'h8);
		repeat (40) begin
			@(posedge aclk);
			chk(!device_reset && timeout_status_flag, "fuse off");
		end
		doze();
		irq_pending <= 1'h1;
		@(posedge aclk);
		irq_pending <= 1'h0;
		n = 0;
		while (resume_exec !== 1'h1 && n < 1200) begin
			@(posedge aclk);
			n++;
		end
		chk(n >= 1023 && n <= 1028, "start-up wait");
	endtask : t_xtal
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		do_reset(1'h1, 1'h0);
		t_regs();
		t_wdt();
		t_freeze();
		t_sleep_irq();
		t_sleep_wdt();
		t_master_clear_pin();
		do_reset(1'h0, 1'h1);
		t_xtal();
		give_verdict();
	end
	// Whole run needs about 1500 cycles
	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end
endmodule : watchdog_and_sleep_wake_control_test

// [wsc_chk.sv]
`timescale 1ns/1ps
// Watches the core-facing power and watchdog outputs only
module wsc_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic crystal_mode,
	input wire logic sleep_instruction,
	input wire logic irq_pending,
	input wire logic global_interrupt_enable,
	input wire logic device_reset,
	input wire logic timeout_status_flag,
	input wire logic powerdown_status_flag,
	input wire logic osc_drive_en,
	input wire logic io_hold,
	input wire logic prefetch_next,
	input wire logic resume_exec,
	input wire logic vector_to_isr,
	input wire logic sleeping
);
	// One domain; the straps only move while reset is low
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_run_exp;
		$fell(timeout_status_flag) && !$past(sleeping) |-> device_reset;
	endproperty
	a_run_exp: assert property (p_run_exp) else $error("expiry without reset");
	property p_slp_exp;
		$fell(timeout_status_flag) && $past(sleeping) |-> !device_reset && !sleeping;
	endproperty
	a_slp_exp: assert property (p_slp_exp) else $error("expiry in sleep reset");
	property p_entry;
		$rose(sleeping) |-> !powerdown_status_flag && timeout_status_flag
			&& io_hold && !osc_drive_en;
	endproperty
	a_entry: assert property (p_entry) else $error("bad sleep entry");
	property p_pd;
		$fell(powerdown_status_flag) |-> prefetch_next;
	endproperty
	a_pd: assert property (p_pd) else $error("powerdown flag cause");
	property p_pref;
		prefetch_next |-> $past(sleep_instruction);
	endproperty
	a_pref: assert property (p_pref) else $error("prefetch without sleep");
	property p_vec;
		vector_to_isr |-> resume_exec && $past(global_interrupt_enable);
	endproperty
	a_vec: assert property (p_vec) else $error("vector without enable");
	property p_wake;
		sleeping && irq_pending && !crystal_mode |=> resume_exec || device_reset;
	endproperty
	a_wake: assert property (p_wake) else $error("no interrupt wake");
	property p_pend;
		prefetch_next && $past(irq_pending) && !crystal_mode |-> resume_exec;
	endproperty
	a_pend: assert property (p_pend) else $error("pending wake missed");
endmodule : wsc_chk

bind wsc_top wsc_chk u_chk (.*);

// [wsc_map.svh]
// Contract
// RQ1 - Watchdog counts on its own free-running clock; here it counts on aclk and freezes while clk_en is low
// RQ2 - Expiry while running forces full device reset
// RQ3 - Expiry while asleep wakes and resumes execution
// RQ4 - Cleared enable fuse disables watchdog completely
// RQ5 - Unprescaled time-out is nominally eighteen milliseconds
// RQ6 - Option register assigns prescaler, up to 1:128
// RQ7 - Clear or sleep instruction clears counter, prescaler
// RQ8 - Expiry clears the active-low time-out flag
// RQ9 - Sleep entry: clear watchdog, flags, stop oscillator, hold
// RQ10 - Watchdog reset never drives master clear pin
// RQ11 - Wake on master clear, watchdog, enabled interrupt
// RQ12 - Power-down flag set at power-up, cleared by sleep
// RQ13 - Only enabled sources wake, regardless of global enable
// RQ14 - Interrupt wake runs next instruction, then maybe vectors
// RQ15 - Sleep prefetches the next sequential instruction
// RQ16 - Pending enabled interrupt at sleep wakes immediately
// RQ17 - Any wake-up clears the watchdog counter
// RQ18 - Crystal modes wait 1024 oscillator periods after wake
// RQ19 - Prescaler rate field selects ratio two to field
`ifndef WSC_MAP_SVH
`define WSC_MAP_SVH

// Register byte addresses; option register keeps its index
`define WSC_OPTION_IDX 12'h081
`define WSC_OPTION_ADDR 12'h204
`define WSC_STATUS_ADDR 12'h000
`define WSC_IRQ_STAT_ADDR 12'h008
`define WSC_IRQ_MASK_ADDR 12'h00C

// Option register fields and reset value
`define WSC_OPTION_RESET 8'hFF
`define WSC_PSA_BIT 3
`define WSC_PS_MSB 2
`define WSC_PS_LSB 0

// Interrupt status bit positions
`define WSC_IRQ_EXPIRE 0
`define WSC_IRQ_WAKE 1
`define WSC_IRQ_SLEEP 2
`define WSC_IRQ_W 3

// Timing
`define WSC_CLK_PERIOD_NS 10
`define WSC_WDT_PERIOD_US 18000
`define WSC_WDT_CYCLES (`WSC_WDT_PERIOD_US * 1000 / `WSC_CLK_PERIOD_NS)
`define WSC_OST_TOSC 1024

`endif

// [wsc_pkg.sv]
package wsc_pkg;
	// Power state of the device core
	typedef enum logic [1:0] {
		WSC_RUN = 2'b00,
		WSC_SLEEP = 2'b01,
		WSC_OST = 2'b10
	} wsc_state_t;

	// Why the core last left sleep
	typedef enum logic [1:0] {
		WSC_WAKE_NONE = 2'b00,
		WSC_WAKE_WDT = 2'b01,
		WSC_WAKE_IRQ = 2'b10
	} wsc_wake_t;
endpackage : wsc_pkg

// [wsc_top.sv]
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "wsc_map.svh"

module wsc_top #(
	parameter int unsigned WDT_CYCLES = `WSC_WDT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic watchdog_enable_fuse,
	input wire logic crystal_mode,
	input wire logic master_clear_pin_n,
	input wire logic watchdog_clear_instruction,
	input wire logic sleep_instruction,
	input wire logic irq_pending,
	input wire logic global_interrupt_enable,
	output logic device_reset,
	output logic master_clear_pin_oe_n,
	output logic timeout_status_flag,
	output logic powerdown_status_flag,
	output logic osc_drive_en,
	output logic io_hold,
	output logic prefetch_next,
	output logic resume_exec,
	output logic vector_to_isr,
	output logic sleeping,
	output logic irq,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] WDT_LAST = 32'(WDT_CYCLES - 1);
	localparam logic [10:0] OST_LAST = 11'(`WSC_OST_TOSC - 1);

	wsc_pkg::wsc_state_t state;
	wsc_pkg::wsc_wake_t wake_cause;
	logic [7:0] option_control;
	logic fuse_on;
	logic xtal_on;
	logic master_clear_pin_s1;
	logic master_clear_pin_s2;
	logic master_clear_pin_s3;
	logic master_clear_pin_low;
	logic master_clear_pin_low_d;
	logic [6:0] prescaler;
	logic [31:0] watchdog_counter;
	logic [10:0] ost_count;
	logic [`WSC_IRQ_W-1:0] irq_status;
	logic [`WSC_IRQ_W-1:0] irq_mask;
	logic aw_held;
	logic w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	logic [6:0] pre_mask;
	logic pre_tick;
	logic wdt_expire;
	logic wdt_clear;
	logic master_clear_pin_event;
	logic sleep_enter;
	logic wake_irq;
	logic wake_any;
	logic ost_done;
	logic wr_fire;
	logic rd_fire;
	logic [`WSC_IRQ_W-1:0] irq_set;
	logic stat_read;
	logic [`WSC_IRQ_W-1:0] next_irq_status;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// Straps are caught while reset is held, so a fuse change later has no effect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fuse_on <= watchdog_enable_fuse;
			xtal_on <= crystal_mode;
		end
	end

	// The master clear pin is asynchronous: three stages, change taken when two agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			master_clear_pin_s1 <= 1'b1;
			master_clear_pin_s2 <= 1'b1;
			master_clear_pin_s3 <= 1'b1;
			master_clear_pin_low <= 1'b0;
			master_clear_pin_low_d <= 1'b0;
		end else if (clk_en) begin
			master_clear_pin_s1 <= master_clear_pin_n;
			master_clear_pin_s2 <= master_clear_pin_s1;
			master_clear_pin_s3 <= master_clear_pin_s2;
			if (master_clear_pin_s2 == master_clear_pin_s3) begin
				master_clear_pin_low <= !master_clear_pin_s3;
			end
			master_clear_pin_low_d <= master_clear_pin_low;
		end
	end

	assign master_clear_pin_event = master_clear_pin_low && !master_clear_pin_low_d; // RQ11

	// Prescaler tap: ratio is 2**rate when assigned, else every cycle
	always_comb begin
		pre_mask = 7'h00;
		if (option_control[`WSC_PSA_BIT]) begin
			pre_mask = 7'((8'h01 << option_control[`WSC_PS_MSB:`WSC_PS_LSB]) - 8'h01); // RQ19
		end
	end

	assign pre_tick = ((prescaler & pre_mask) == pre_mask); // RQ6
	assign wdt_expire = fuse_on && pre_tick && (watchdog_counter == WDT_LAST); // RQ4 RQ5

	// Sleep entry is only honoured from run; a pending enabled source still lets it finish
	assign sleep_enter = (state == wsc_pkg::WSC_RUN) && sleep_instruction;
	assign wake_irq = (state == wsc_pkg::WSC_SLEEP) && irq_pending; // RQ13
	assign wake_any = (state == wsc_pkg::WSC_SLEEP) && (wdt_expire || irq_pending);
	assign ost_done = (state == wsc_pkg::WSC_OST) && (ost_count == OST_LAST);
	assign wdt_clear = watchdog_clear_instruction || sleep_enter || wake_any; // RQ7 RQ17

	// The counter keeps running on aclk whether or not the core oscillator is driven
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prescaler <= 7'h00;
			watchdog_counter <= 32'h0000_0000;
		end else if (clk_en) begin
			if (wdt_clear || wdt_expire || master_clear_pin_event || !fuse_on) begin
				prescaler <= 7'h00; // RQ7
				watchdog_counter <= 32'h0000_0000; // RQ7
			end else begin
				prescaler <= prescaler + 7'h01; // RQ1
				if (pre_tick) begin
					watchdog_counter <= watchdog_counter + 32'h0000_0001; // RQ1
				end
			end
		end
	end

	// Power state machine: run, sleep, oscillator start-up wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= wsc_pkg::WSC_RUN;
			wake_cause <= wsc_pkg::WSC_WAKE_NONE;
			ost_count <= 11'h000;
		end else if (clk_en) begin
			unique case (state)
				wsc_pkg::WSC_RUN: begin
					ost_count <= 11'h000;
					if (sleep_enter) begin
						if (irq_pending) begin
							state <= xtal_on ? wsc_pkg::WSC_OST : wsc_pkg::WSC_RUN; // RQ16
							wake_cause <= wsc_pkg::WSC_WAKE_IRQ; // RQ16
						end else begin
							state <= wsc_pkg::WSC_SLEEP; // RQ9
						end
					end
				end
				wsc_pkg::WSC_SLEEP: begin
					ost_count <= 11'h000;
					if (master_clear_pin_event) begin
						state <= wsc_pkg::WSC_RUN; // RQ11
						wake_cause <= wsc_pkg::WSC_WAKE_NONE;
					end else if (wake_any) begin
						state <= xtal_on ? wsc_pkg::WSC_OST : wsc_pkg::WSC_RUN; // RQ18
						wake_cause <= irq_pending ? wsc_pkg::WSC_WAKE_IRQ : wsc_pkg::WSC_WAKE_WDT;
					end
				end
				wsc_pkg::WSC_OST: begin
					ost_count <= ost_count + 11'h001; // RQ18
					if (master_clear_pin_event) begin
						state <= wsc_pkg::WSC_RUN;
						wake_cause <= wsc_pkg::WSC_WAKE_NONE;
					end else if (ost_done) begin
						state <= wsc_pkg::WSC_RUN; // RQ18
					end
				end
				default: begin
					state <= wsc_pkg::WSC_RUN;
				end
			endcase
		end
	end

	// Core-facing strobes; resume fires once the clock is usable again
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			device_reset <= 1'b0;
			prefetch_next <= 1'b0;
			resume_exec <= 1'b0;
			vector_to_isr <= 1'b0;
		end else if (clk_en) begin
			device_reset <= master_clear_pin_event || ((state == wsc_pkg::WSC_RUN) && wdt_expire); // RQ2 RQ11
			prefetch_next <= sleep_enter; // RQ15
			if ((sleep_enter && irq_pending && !xtal_on) || ost_done) begin
				resume_exec <= !(ost_done && master_clear_pin_event); // RQ3 RQ14
				vector_to_isr <= global_interrupt_enable && (ost_done ?
					(wake_cause == wsc_pkg::WSC_WAKE_IRQ) : 1'b1); // RQ14
			end else if (wake_any && !xtal_on && !master_clear_pin_event) begin
				resume_exec <= 1'b1; // RQ3
				vector_to_isr <= global_interrupt_enable && wake_irq; // RQ14
			end else begin
				resume_exec <= 1'b0;
				vector_to_isr <= 1'b0;
			end
		end
	end

	// Power-state outputs: oscillator off and pins frozen only while asleep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_drive_en <= 1'b1;
			io_hold <= 1'b0;
			sleeping <= 1'b0;
			master_clear_pin_oe_n <= 1'b1;
		end else if (clk_en) begin
			master_clear_pin_oe_n <= 1'b1; // RQ10
			if (sleep_enter && !irq_pending) begin
				osc_drive_en <= 1'b0; // RQ9
				io_hold <= 1'b1; // RQ9
				sleeping <= 1'b1;
			end else if (wake_any || master_clear_pin_event) begin
				osc_drive_en <= 1'b1;
				io_hold <= 1'b0;
				sleeping <= 1'b0;
			end
		end
	end

	// Status flags, both active low; only power-up sets them from reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_status_flag <= 1'b1;
			powerdown_status_flag <= 1'b1; // RQ12
		end else if (clk_en) begin
			if (wdt_expire) begin
				timeout_status_flag <= 1'b0; // RQ8
			end else if (watchdog_clear_instruction || sleep_enter) begin
				timeout_status_flag <= 1'b1; // RQ9
			end
			if (sleep_enter) begin
				powerdown_status_flag <= 1'b0; // RQ12
			end else if (watchdog_clear_instruction) begin
				powerdown_status_flag <= 1'b1;
			end
		end
	end

	// AXI write: address and data may come in either order, response after both
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= ((aw_addr == `WSC_OPTION_ADDR) || (aw_addr == `WSC_IRQ_MASK_ADDR)
					|| (aw_addr == `WSC_STATUS_ADDR) || (aw_addr == `WSC_IRQ_STAT_ADDR))
					? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Writable registers; only byte lane 0 carries data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			option_control <= `WSC_OPTION_RESET;
			irq_mask <= '0;
		end else if (clk_en && wr_fire && w_strb[0]) begin
			if (aw_addr == `WSC_OPTION_ADDR) begin
				option_control <= w_data[7:0]; // RQ6
			end
			if (aw_addr == `WSC_IRQ_MASK_ADDR) begin
				irq_mask <= w_data[`WSC_IRQ_W-1:0];
			end
		end
	end

	// AXI read: one at a time, data registered one cycle after the address
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_rresp = RESP_OKAY;
		unique case (s_axi_araddr)
			`WSC_STATUS_ADDR: begin
				next_rdata[7:0] = {xtal_on, fuse_on, wake_cause, state,
					timeout_status_flag, powerdown_status_flag};
			end
			`WSC_OPTION_ADDR: begin
				next_rdata[7:0] = option_control;
			end
			`WSC_IRQ_STAT_ADDR: begin
				next_rdata[`WSC_IRQ_W-1:0] = irq_status;
			end
			`WSC_IRQ_MASK_ADDR: begin
				next_rdata[`WSC_IRQ_W-1:0] = irq_mask;
			end
			default: begin
				next_rresp = RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Sticky event bits cleared by reading them; a new event in that cycle survives
	assign stat_read = rd_fire && (s_axi_araddr == `WSC_IRQ_STAT_ADDR);

	always_comb begin
		irq_set = '0;
		irq_set[`WSC_IRQ_EXPIRE] = wdt_expire;
		irq_set[`WSC_IRQ_WAKE] = wake_any;
		irq_set[`WSC_IRQ_SLEEP] = sleep_enter;
		next_irq_status = (stat_read ? '0 : irq_status) | irq_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= '0;
			irq <= 1'b0;
		end else if (clk_en) begin
			irq_status <= next_irq_status;
			irq <= |(next_irq_status & irq_mask);
		end
	end

endmodule : wsc_top
